// [verilog/fca_flash_cmd.v]
`timescale 1ns/10ps
`include "fca_flash_cmd_defs.vh"

module fca_flash_cmd (
	input  wire                   clk_in,
	input  wire                   resetn_in,
	input  wire                   in_valid_in,
	input  wire [7:0]             in_data_in,
	input  wire                   in_last_in,
	output wire                   in_ready_out,
	input  wire                   frame_network_in,
	input  wire [7:0]             frame_type_in,
	input  wire [15:0]            frame_cluster_in,
	input  wire [7:0]             frame_dest_ep_in,
	input  wire [7:0]             frame_src_ep_in,
	input  wire [15:0]            frame_udp_port_in,
	input  wire [7:0]             frame_app_len_in,
	input  wire                   frame_broadcast_in,
	input  wire                   explicit_out_en_in,
	input  wire                   api_mode_en_in,
	output wire                   out_valid_out,
	output wire [7:0]             out_data_out,
	output wire                   out_last_out,
	input  wire                   out_ready_in,
	output reg  [7:0]             resp_endpoint_out,
	output reg                    resp_indicator_out,
	output reg                    busy_out,
	input  wire                   prog_valid_in,
	input  wire [`FCA_ADDR_W-1:0] prog_addr_in,
	input  wire [7:0]             prog_data_in,
	output wire                   prog_ready_out,
	input  wire [`FCA_ADDR_W-1:0] rd_addr_in,
	output reg  [7:0]             rd_data_out
);

	// =================================================================
	// State encoding
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_SKIP  = 3'h1;
	localparam [2:0] S_HDR   = 3'h2;
	localparam [2:0] S_DRAIN = 3'h3;
	localparam [2:0] S_DEC   = 3'h4;
	localparam [2:0] S_ERASE = 3'h5;
	localparam [2:0] S_RESP  = 3'h6;
	localparam [2:0] S_DROP  = 3'h7;

	reg  [2:0]             state;
	reg  [7:0]             skip_cnt;
	reg  [2:0]             hdr_idx;
	reg  [63:0]            hdr;
	reg                    bcast;
	reg  [7:0]             rsp_code;
	reg  [7:0]             rsp_status;
	reg  [15:0]            rsp_blk;
	reg  [15:0]            rsp_ofs;
	reg  [2:0]             rsp_idx;
	reg  [`FCA_ADDR_W-1:0] er_addr;
	reg  [`FCA_ADDR_W-1:0] er_end;
	reg  [7:0]             store [0:`FCA_STORE_WORDS-1];

	wire [7:0]  h_code = hdr[`FCA_CODE_MSB:`FCA_CODE_LSB];
	wire [15:0] h_blk  = hdr[`FCA_BLK_MSB:`FCA_BLK_LSB];
	wire [15:0] h_ofs  = hdr[`FCA_OFS_MSB:`FCA_OFS_LSB];
	wire [15:0] h_cnt  = hdr[`FCA_CNT_MSB:`FCA_CNT_LSB];
	wire        take   = in_valid_in & in_ready_out;

	// =================================================================
	// Carrier match
	wire serial_ok = (frame_type_in == `FCA_FRAME_EXPLICIT) &&
		(frame_cluster_in == `FCA_CLUSTER_MEMORY) &&
		(frame_dest_ep_in == `FCA_ENDPOINT_DEVICE);
	wire net_ok = (frame_udp_port_in == `FCA_UDP_PORT);
	wire frame_ok = frame_network_in ? net_ok : serial_ok;

	assign in_ready_out = (state == S_SKIP) || (state == S_HDR) ||
		(state == S_DRAIN) || (state == S_DROP);

	// =================================================================
	// Two-entry reply buffer
	reg  [8:0] fbuf [0:1];
	reg        f_wp;
	reg        f_rp;
	reg  [1:0] f_cnt;
	reg  [7:0] push_byte;
	wire       f_full = (f_cnt == 2'h2);
	wire       push   = (state == S_RESP) && !f_full;
	wire       pop    = out_valid_out && out_ready_in;

	assign out_valid_out = (f_cnt != 2'h0);
	assign out_data_out  = fbuf[f_rp][7:0];
	assign out_last_out  = fbuf[f_rp][8];

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			f_wp  <= 1'b0;
			f_rp  <= 1'b0;
			f_cnt <= 2'h0;
		end else begin
			if (push) begin
				fbuf[f_wp] <= {(rsp_idx == `FCA_HDR_LAST), push_byte};
				f_wp       <= ~f_wp;
			end
			if (pop)
				f_rp <= ~f_rp;
			if (push && !pop)
				f_cnt <= f_cnt + 2'h1;
			else if (pop && !push)
				f_cnt <= f_cnt - 2'h1;
		end
	end

	// =================================================================
	// Reply byte order, high byte of each field first
	always @* begin
		case (rsp_idx)
		3'h0: push_byte = rsp_code;
		3'h1: push_byte = rsp_status;
		3'h2: push_byte = rsp_blk[15:8];
		3'h3: push_byte = rsp_blk[7:0];
		3'h4: push_byte = rsp_ofs[15:8];
		3'h5: push_byte = rsp_ofs[7:0];
		default: push_byte = 8'h00;
		endcase
	end

	// =================================================================
	// Command sequencing
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			state              <= S_IDLE;
			skip_cnt           <= 8'h00;
			hdr_idx            <= 3'h0;
			hdr                <= 64'h0;
			bcast              <= 1'b0;
			rsp_code           <= 8'h00;
			rsp_status         <= 8'h00;
			rsp_blk            <= 16'h0000;
			rsp_ofs            <= 16'h0000;
			rsp_idx            <= 3'h0;
			er_addr            <= {`FCA_ADDR_W{1'b0}};
			er_end             <= {`FCA_ADDR_W{1'b0}};
			resp_endpoint_out  <= 8'h00;
			resp_indicator_out <= 1'b0;
			busy_out           <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				busy_out <= 1'b0;
				hdr_idx  <= 3'h0;
				if (in_valid_in) begin
					busy_out          <= 1'b1;
					bcast             <= frame_broadcast_in;
					resp_endpoint_out <= frame_src_ep_in;
					resp_indicator_out <= api_mode_en_in &&
						((frame_src_ep_in == `FCA_ENDPOINT_DEVICE) ||
						explicit_out_en_in);
					skip_cnt <= frame_app_len_in;
					if (!frame_ok)
						state <= S_DROP;
					else if (frame_network_in &&
						frame_app_len_in != 8'h00)
						state <= S_SKIP;
					else
						state <= S_HDR;
				end
			end
			S_SKIP: begin
				if (take) begin
					skip_cnt <= skip_cnt - 8'h01;
					if (in_last_in)
						state <= S_IDLE;
					else if (skip_cnt == 8'h01)
						state <= S_HDR;
				end
			end
			S_HDR: begin
				if (take) begin
					hdr     <= {hdr[55:0], in_data_in};
					hdr_idx <= hdr_idx + 3'h1;
					if (hdr_idx == `FCA_HDR_LAST)
						state <= in_last_in ? S_DEC : S_DRAIN;
					else if (in_last_in)
						state <= S_IDLE;
				end
			end
			S_DRAIN: begin
				// Trailing data is not meaningful for either command.
				if (take && in_last_in)
					state <= S_DEC;
			end
			S_DROP: begin
				if (take && in_last_in)
					state <= S_IDLE;
			end
			S_DEC: begin
				rsp_idx    <= 3'h0;
				rsp_status <= 8'h00;
				rsp_blk    <= h_blk;
				rsp_ofs    <= h_ofs;
				rsp_code   <= h_code | `FCA_RSP_FLAG;
				state      <= bcast ? S_IDLE : S_RESP;
				if (h_code == `FCA_CMD_GEOMETRY) begin
					rsp_code <= `FCA_RSP_GEOMETRY;
					rsp_blk  <= `FCA_BLOCK_COUNT;
					rsp_ofs  <= `FCA_BLOCK_SIZE;
				end else if (h_code == `FCA_CMD_ERASE) begin
					rsp_code <= `FCA_RSP_ERASE;
					if (h_cnt == 16'h0000) begin
						er_addr <= {`FCA_ADDR_W{1'b0}};
						er_end  <= `FCA_ADDR_TOP;
						state   <= S_ERASE;
					end else if (h_blk > `FCA_BLOCK_LAST ||
						h_cnt != `FCA_BLOCK_SIZE ||
						h_ofs != 16'h0000) begin
						rsp_status[`FCA_STATUS_ERR_BIT] <= 1'b1;
					end else begin
						er_addr <= {h_blk[7:0], {`FCA_OFS_W{1'b0}}};
						er_end  <= {h_blk[7:0], {`FCA_OFS_W{1'b1}}};
						state   <= S_ERASE;
					end
				end else begin
					rsp_status[`FCA_STATUS_ERR_BIT] <= 1'b1;
				end
			end
			S_ERASE: begin
				er_addr <= er_addr + {{(`FCA_ADDR_W-1){1'b0}}, 1'b1};
				if (er_addr == er_end)
					state <= bcast ? S_IDLE : S_RESP;
			end
			S_RESP: begin
				if (push) begin
					rsp_idx <= rsp_idx + 3'h1;
					if (rsp_idx == `FCA_HDR_LAST)
						state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// =================================================================
	// Store array
	// Erase owns the array while it runs, so programming waits for it.
	assign prog_ready_out = (state != S_ERASE);

	always @(posedge clk_in) begin
		if (state == S_ERASE)
			store[er_addr] <= `FCA_ERASED_BYTE;
		else if (prog_valid_in)
			store[prog_addr_in] <= store[prog_addr_in] &
				prog_data_in;
		rd_data_out <= store[rd_addr_in];
	end

endmodule // fca_flash_cmd

// [verilog/fca_flash_cmd_defs.vh]
`ifndef FCA_FLASH_CMD_DEFS_VH
`define FCA_FLASH_CMD_DEFS_VH

// =====================================================================
// Carrier recognition
`define FCA_FRAME_EXPLICIT   8'h11
`define FCA_CLUSTER_MEMORY   16'h0023
`define FCA_ENDPOINT_DEVICE  8'he6
`define FCA_UDP_PORT         16'h0bee

// =====================================================================
// Command and response codes
`define FCA_CMD_GEOMETRY     8'h00
`define FCA_CMD_ERASE        8'h01
`define FCA_RSP_GEOMETRY     8'h80
`define FCA_RSP_ERASE        8'h81
`define FCA_RSP_FLAG         8'h80

// =====================================================================
// Header layout, big-endian, as a 64-bit word with byte 0 on top
`define FCA_HDR_BYTES        4'h8
`define FCA_HDR_LAST         3'h7
`define FCA_CODE_MSB         63
`define FCA_CODE_LSB         56
`define FCA_OPT_MSB          55
`define FCA_OPT_LSB          48
`define FCA_BLK_MSB          47
`define FCA_BLK_LSB          32
`define FCA_OFS_MSB          31
`define FCA_OFS_LSB          16
`define FCA_CNT_MSB          15
`define FCA_CNT_LSB          0
`define FCA_STATUS_ERR_BIT   0

// =====================================================================
// Store geometry
`define FCA_BLOCK_COUNT      16'h00a0
`define FCA_BLOCK_LAST       16'h009f
`define FCA_BLOCK_SIZE       16'h1000
`define FCA_ADDR_W           20
`define FCA_OFS_W            12
`define FCA_STORE_WORDS      655360
`define FCA_ADDR_TOP         20'h9ffff
`define FCA_ERASED_BYTE      8'hff

`endif

// [verification/fca_flash_cmd_monitor.sv]
`timescale 1ns/10ps
// ==========================================================
// Reply stream checks.
module fca_flash_cmd_monitor (
	input wire       clk_in,
	input wire       resetn_in,
	input wire       busy_out,
	input wire       out_valid_out,
	input wire [7:0] out_data_out,
	input wire       out_last_out,
	input wire       out_ready_in,
	input wire [7:0] resp_endpoint_out,
	input wire       resp_indicator_out,
	input wire [7:0] frame_src_ep_in,
	input wire       frame_broadcast_in,
	input wire       api_mode_en_in,
	input wire       explicit_out_en_in
);
	reg [2:0] nb;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Position of the byte now offered, so each field is judged in place.
	always @(posedge clk_in) begin
		if (!resetn_in)
			nb <= 3'h0;
		else if (out_valid_out && out_ready_in)
			nb <= out_last_out ? 3'h0 : nb + 3'h1;
	end
	reply_length_a: assert property (out_valid_out && out_last_out
		|-> nb == 3'h7) else $error("reply length wrong");
	reply_code_a: assert property (out_valid_out && nb == 3'h0
		|-> out_data_out[7]) else $error("reply code flag missing");
	status_high_a: assert property (out_valid_out && nb == 3'h1
		|-> out_data_out[7:1] == 7'h00) else $error("status high bits set");
	count_zero_a: assert property (out_valid_out && nb[2:1] == 2'h3
		|-> out_data_out == 8'h00) else $error("reply count not zero");
	reply_hold_a: assert property (out_valid_out && !out_ready_in
		|=> out_valid_out && $stable(out_data_out) && $stable(out_last_out))
		else $error("reply byte lost in stall");
	endpoint_echo_a: assert property (out_valid_out
		|-> resp_endpoint_out == frame_src_ep_in) else $error("endpoint");
	indicator_level_a: assert property (out_valid_out |->
		resp_indicator_out ==
		(api_mode_en_in && (frame_src_ep_in == 8'he6 || explicit_out_en_in)))
		else $error("indicator wrong");
	bcast_silent_a: assert property (frame_broadcast_in && busy_out
		|-> !out_valid_out) else $error("broadcast answered");
endmodule // fca_flash_cmd_monitor

bind fca_flash_cmd fca_flash_cmd_monitor u_mon (.clk_in(clk_in),
	.resetn_in(resetn_in), .busy_out(busy_out), .out_valid_out(out_valid_out),
	.out_data_out(out_data_out), .out_last_out(out_last_out),
	.out_ready_in(out_ready_in), .resp_endpoint_out(resp_endpoint_out),
	.resp_indicator_out(resp_indicator_out), .frame_src_ep_in(frame_src_ep_in),
	.frame_broadcast_in(frame_broadcast_in), .api_mode_en_in(api_mode_en_in),
	.explicit_out_en_in(explicit_out_en_in));

// [verification/fca_req.sv]
`timescale 1ns/10ps
// ==========================================================
// Requester: sends one frame per start, sinks the reply.
module fca_req (
	input  wire        clk_in,
	input  wire        start_in,
	input  wire [63:0] hdr_in,
	input  wire [7:0]  app_len_in,
	input  wire [7:0]  extra_in,
	input  wire        stall_in,
	input  wire        ready_in,
	output reg         valid_out = 1'b0,
	output wire [7:0]  data_out,
	output wire        last_out,
	input  wire        rsp_valid_in,
	input  wire [7:0]  rsp_data_in,
	input  wire        rsp_last_in,
	output wire        rsp_ready_out,
	output reg  [63:0] rsp_out = 64'h0,
	output reg         got_out = 1'b0
);
	reg  [7:0] idx = 8'h00;
	reg  [7:0] prev = 8'h00;
	reg  [3:0] tick = 4'h0;
	wire [7:0] hpos = idx - app_len_in;
	// Idle data is the inverse of the last byte, so no stale value passes.
	assign data_out = !valid_out ? ~prev : (idx < app_len_in) ? 8'haa
		: (hpos > 8'h07) ? 8'h55
		: hdr_in[6'd63 - {hpos[2:0], 3'h0} -: 8];
	// Trailing payload bytes only appear when a scenario asks for them.
	assign last_out = valid_out &&
		(idx == app_len_in + 8'h07 + extra_in);
	assign rsp_ready_out = !stall_in || tick[1];
	always @(posedge clk_in) begin
		tick <= tick + 4'h1;
		if (start_in) begin
			valid_out <= 1'b1;
			idx <= 8'h00;
			got_out <= 1'b0;
		end else if (valid_out && ready_in) begin
			idx <= idx + 8'h01;
			prev <= data_out;
			if (last_out)
				valid_out <= 1'b0;
		end
		if (rsp_valid_in && rsp_ready_out) begin
			rsp_out <= {rsp_out[55:0], rsp_data_in};
			if (rsp_last_in)
				got_out <= 1'b1;
		end
	end
endmodule // fca_req

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic        clk_in = 1'b0, resetn_in = 1'b0, start = 1'b0, bcast = 1'b0;
	logic        net = 1'b0, prog_v = 1'b0;
	logic [63:0] hdr = 64'h0;
	logic [7:0]  app = 8'h00, ftype = 8'h11, src = 8'he6, prog_d = 8'h00;
	logic [7:0]  extra = 8'h00;
	logic        expl = 1'b0, api = 1'b1;
	logic [15:0] cluster = 16'h0023, port = 16'h0bee;
	logic [19:0] rd_a = 20'h0, prog_a = 20'h05003;
	wire  [7:0]  in_d, o_d, rd_d, ep;
	wire  [63:0] rsp;
	wire         in_v, in_l, in_rdy, o_v, o_l, o_rdy, busy, prog_rdy, got, ind;
	int          n_errors = 0, num_checks = 0, i;
	logic [63:0] hdr_t [0:4] = '{64'h0, 64'h0100000500001000,
		64'h010000a000001000, 64'h0100009f00011000, 64'h0700000300040000};
	logic [63:0] exp_t [0:4] = '{64'h800000a010000000, 64'h8100000500000000,
		64'h810100a000000000, 64'h8101009f00010000, 64'h8701000300040000};
	always #2.5 clk_in = ~clk_in;
	fca_flash_cmd DUT (.clk_in(clk_in), .resetn_in(resetn_in),
		.in_valid_in(in_v), .in_data_in(in_d), .in_last_in(in_l),
		.in_ready_out(in_rdy), .frame_network_in(net), .frame_type_in(ftype),
		.frame_cluster_in(cluster), .frame_dest_ep_in(8'he6),
		.frame_src_ep_in(src), .frame_udp_port_in(port), .frame_app_len_in(app),
		.frame_broadcast_in(bcast), .explicit_out_en_in(expl),
		.api_mode_en_in(api), .out_valid_out(o_v), .out_data_out(o_d),
		.out_last_out(o_l), .out_ready_in(o_rdy), .resp_endpoint_out(ep),
		.resp_indicator_out(ind), .busy_out(busy), .prog_valid_in(prog_v),
		.prog_addr_in(prog_a), .prog_data_in(prog_d), .prog_ready_out(prog_rdy),
		.rd_addr_in(rd_a), .rd_data_out(rd_d));
	fca_req u_req (.clk_in(clk_in), .start_in(start), .hdr_in(hdr),
		.app_len_in(app), .extra_in(extra), .stall_in(1'b1),
		.ready_in(in_rdy), .valid_out(in_v),
		.data_out(in_d), .last_out(in_l), .rsp_valid_in(o_v), .rsp_data_in(o_d),
		.rsp_last_in(o_l), .rsp_ready_out(o_rdy), .rsp_out(rsp), .got_out(got));
	task automatic check(input [63:0] seen, input [63:0] want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic run(input [63:0] h, input [7:0] al, input nt,
		input [7:0] ty, input [15:0] pt, input bc, input eg, input [63:0] ex);
		int k;
		hdr = h; app = al; net = nt; ftype = ty; port = pt; bcast = bc;
		start = 1'b1;
		@(posedge clk_in);
		#1 start = 1'b0;
		k = 0;
		while ((in_v || busy || o_v) && k < 9000) begin
			@(posedge clk_in);
			#1 k++;
		end
		check({63'h0, k >= 9000}, 64'h0);
		check({63'h0, got}, {63'h0, eg});
		check({56'h0, ep}, {56'h0, src});
		check({63'h0, ind}, {63'h0, api && (src == 8'he6 || expl)});
		if (eg)
			check(rsp, ex);
	endtask
	task automatic prog(input [7:0] d);
		@(posedge clk_in);
		#1 prog_d = d;
		prog_v = 1'b1;
		// Ready is judged before the edge that takes the byte.
		while (!prog_rdy) begin
			@(posedge clk_in);
			#1;
		end
		@(posedge clk_in);
		#1 prog_v = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_in);
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		for (i = 0; i < 5; i++)
			run(hdr_t[i], 0, 0, 8'h11, 0, 0, 1, exp_t[i]);
		rd_a = 20'h05003;
		@(posedge clk_in);
		#1 check({56'h0, rd_d}, 64'hff);
		prog(8'h5a);
		prog(8'h0f);
		@(posedge clk_in);
		#1 check({56'h0, rd_d}, 64'h0a);
		run(0, 0, 0, 8'h11, 0, 1, 0, 0);
		run(0, 0, 0, 8'h10, 0, 0, 0, 0);
		cluster = 16'h0024;
		run(0, 0, 0, 8'h11, 0, 0, 0, 0);
		cluster = 16'h0023;
		src = 8'h42;
		run(0, 3, 1, 8'h00, 16'h0bee, 0, 1, exp_t[0]);
		run(0, 3, 1, 8'h00, 16'h0bef, 0, 0, 0);
		expl = 1'b1;
		run(0, 0, 0, 8'h11, 0, 0, 1, exp_t[0]);
		api = 1'b0;
		run(0, 0, 0, 8'h11, 0, 0, 1, exp_t[0]);
		api = 1'b1;
		expl = 1'b0;
		extra = 8'h02;
		run(hdr_t[4], 0, 0, 8'h11, 0, 0, 1, exp_t[4]);
		extra = 8'h00;
		// A full erase of the store outlasts the run, so it is cut by reset.
		hdr = 64'h010000a000000000;
		app = 8'h00;
		net = 1'b0;
		ftype = 8'h11;
		bcast = 1'b0;
		start = 1'b1;
		@(posedge clk_in);
		#1 start = 1'b0;
		rd_a = 20'h00010;
		repeat (40) @(posedge clk_in);
		#1 check({63'h0, prog_rdy}, 64'h0);
		check({56'h0, rd_d}, 64'hff);
		resetn_in = 1'b0;
		repeat (2) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		repeat (2) begin
			@(posedge clk_in);
			#1 check({61'h0, busy, o_v, in_rdy}, 64'h0);
			check({63'h0, prog_rdy}, 64'h1);
		end
		rd_a = 20'h05003;
		@(posedge clk_in);
		#1 check({56'h0, rd_d}, 64'h0a);
		run(0, 0, 0, 8'h11, 0, 0, 1, exp_t[0]);
		report_and_stop;
	end
endmodule // tb_top
